//--- misc_status_control_exec_tb.sv
/*
  Self-checking bench for the miscellaneous execution block.
  Assumes the far-side model stands in for console and devices.
*/
`timescale 1ns/100ps
`default_nettype none
module misc_status_control_exec_tb;
  localparam int unsigned INIT_N = 8;
  logic clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, instr_valid = 1'b0;
  logic single_op = 1'b0, is_byte = 1'b0, slow = 1'b0;
  logic [3:0] reg_addr = 4'h0, mem_cycles = 4'h3;
  logic [15:0] reg_wdata = 16'h0000, instr = 16'h0000, instr_pc = 16'h0000;
  logic [15:0] dst_time_ns = 16'h012c, ef_time_ns = 16'h07c6;
  logic [7:0] src_byte = 8'h00;
  logic [2:0] dst_mode = 3'h0;
  wire logic [15:0] reg_rdata, dst_data, console_display, instr_time_ns;
  wire logic [7:0] proc_status;
  wire logic dst_wr, dst_byte, halted, bus_abort, fetch_en, irq_grant, bus_init, time_valid;
  wire logic console_continue_key, irq_pending;
  int num_errors = 0, n_checks = 0;
  always #50 clk = ~clk;
  mse_exec #(.INIT_CYCLES(INIT_N)) dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .instr_valid(instr_valid), .instr(instr), .instr_pc(instr_pc), .src_byte(src_byte),
    .dst_mode(dst_mode), .single_op(single_op), .is_byte(is_byte),
    .dst_time_ns(dst_time_ns), .ef_time_ns(ef_time_ns), .mem_cycles(mem_cycles),
    .console_continue_key(console_continue_key), .irq_pending(irq_pending),
    .proc_status(proc_status), .dst_wr(dst_wr), .dst_data(dst_data), .dst_byte(dst_byte),
    .halted(halted), .console_display(console_display), .bus_abort(bus_abort),
    .fetch_en(fetch_en), .irq_grant(irq_grant), .bus_init(bus_init),
    .instr_time_ns(instr_time_ns), .time_valid(time_valid));
  mse_far_model far (.clk(clk), .sys_rst(sys_rst), .slow(slow), .halted(halted),
    .fetch_en(fetch_en), .bus_init(bus_init), .irq_grant(irq_grant),
    .console_continue_key(console_continue_key), .irq_pending(irq_pending));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_sim();
    if (num_errors == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_read(input string what, input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(what, exp, reg_rdata);
  endtask
  // Issue one instruction; returns with the first answer cycle settled
  task automatic run_instr(input logic [15:0] w, input logic [15:0] pc, input logic [7:0] sb,
                           input logic [2:0] m);
    @(posedge clk);
    instr <= w;
    instr_pc <= pc;
    src_byte <= sb;
    dst_mode <= m;
    instr_valid <= 1'b1;
    @(posedge clk);
    instr_valid <= 1'b0;
    #1;
  endtask
  function automatic logic [15:0] move_to_status_w();
    return {mse_pkg::OP_MOVE_TO_STATUS_HI, 6'h00};
  endfunction
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    chk("ps", 16'h0000, {8'h00, proc_status});
    chk("fetch_en", 16'h0001, {15'h0000, fetch_en});
    reg_read("ctrl", mse_pkg::REG_CTRL, 16'h0000);
    reg_read("unmapped", 4'hf, 16'h0000);
  endtask
  task automatic t_ccop();
    for (int i = 1; i < 16; i++) begin
      run_instr({12'h00b, 4'(i)}, 16'h0000, 8'h00, 3'h0);
      chk("ccop set", {12'h000, 4'(i)}, {8'h00, proc_status});
      run_instr({12'h00a, 4'(i)}, 16'h0000, 8'h00, 3'h0);
      chk("ccop clr", 16'h0000, {8'h00, proc_status});
    end
  endtask
  task automatic t_move_to_status();
    run_instr(move_to_status_w(), 16'h0000, 8'hff, 3'h0);
    chk("move_to_status ps", 16'h00ef, {8'h00, proc_status});
    chk("move_to_status no write", 16'h0000, {15'h0000, dst_wr});
    run_instr(move_to_status_w(), 16'h0000, 8'h1a, 3'h0);
    chk("move_to_status ps2", 16'h000a, {8'h00, proc_status});
  endtask
  // Status byte out to a destination, flags adjusted
  task automatic move_from_status_case(input logic [7:0] ps0, input logic [2:0] m,
                           input logic [15:0] d_exp, input logic [7:0] ps_exp);
    run_instr(move_to_status_w(), 16'h0000, ps0, 3'h0);
    run_instr({mse_pkg::OP_MOVE_FROM_STATUS_HI, m, 3'h0}, 16'h0000, 8'h00, m);
    chk("move_from_status wr", 16'h0003, {14'h0000, dst_wr, dst_byte});
    chk("move_from_status data", d_exp, dst_data);
    chk("move_from_status ps", {8'h00, ps_exp}, {8'h00, proc_status});
  endtask
  task automatic t_halt();
    slow <= 1'b1;
    run_instr(mse_pkg::OP_HALT, 16'h1236, 8'h00, 3'h0);
    chk("halt", 16'h0001, {15'h0000, halted});
    chk("display", 16'h1236, console_display);
    chk("abort init", 16'h0002, {14'h0000, bus_abort, bus_init});
    chk("halt fetch", 16'h0000, {15'h0000, fetch_en});
    reg_read("status", mse_pkg::REG_STATUS, 16'h0001);
    run_instr(16'h00bf, 16'h0000, 8'h00, 3'h0);
    chk("halt ignores", 16'h0004, {8'h00, proc_status});
    for (int n = 0; n < 40 && halted === 1'b1; n++) @(posedge clk) #1;
    chk("resume", 16'h0001, {14'h0000, halted, fetch_en});
  endtask
  task automatic t_wait(input logic s);
    slow <= s;
    run_instr(mse_pkg::OP_WAIT, 16'h0000, 8'h00, 3'h0);
    repeat (s ? 12 : 1) begin
      chk("wait bus", 16'h0000, {15'h0000, fetch_en});
      @(posedge clk) #1;
    end
    for (int n = 0; n < 40 && irq_grant !== 1'b1; n++) @(posedge clk) #1;
    chk("grant", 16'h0003, {14'h0000, irq_grant, fetch_en});
    @(posedge clk) #1 chk("grant pulse", 16'h0000, {15'h0000, irq_grant});
  endtask
  task automatic t_bus_reset();
    int n = 0;
    run_instr(16'h00bb, 16'h0000, 8'h00, 3'h0);
    run_instr(mse_pkg::OP_RESET, 16'h0000, 8'h00, 3'h0);
    chk("init c1", 16'h0002, {14'h0000, bus_init, fetch_en});
    while (bus_init === 1'b1 && n < 100) begin
      n++;
      @(posedge clk) #1;
    end
    chk("init len", 16'(INIT_N), 16'(n));
    chk("after init", 16'h0000, {15'h0000, fetch_en});
    @(posedge clk) #1 chk("refetch", 16'h0001, {15'h0000, fetch_en});
    chk("init flags", 16'h000f, {8'h00, proc_status});
  endtask
  task automatic t_time();
    logic [15:0] e;
    for (int i = 0; i < 4; i++) begin
      if (i == 3) reg_write(mse_pkg::REG_CTRL, 16'h0001);
      @(posedge clk);
      single_op <= (i != 2);
      is_byte <= (i == 1);
      e = ef_time_ns + ((i != 2) ? dst_time_ns : 16'h0000) + ((i == 3) ? 16'h0168 : 16'h0000);
      run_instr(16'h00a0, 16'h0000, 8'h00, 3'h0);
      chk("time valid", 16'h0001, {15'h0000, time_valid});
      chk("time", e, instr_time_ns);
    end
    reg_read("time reg", mse_pkg::REG_TIME, e);
    reg_read("ctrl mm", mse_pkg::REG_CTRL, 16'h0001);
  endtask
  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_ccop();
    t_move_to_status();
    move_from_status_case(8'h85, 3'h0, 16'hff85, 8'h89);
    move_from_status_case(8'h89, 3'h2, 16'h0089, 8'h89);
    move_from_status_case(8'h02, 3'h1, 16'h0002, 8'h00);
    move_from_status_case(8'h00, 3'h0, 16'h0000, 8'h04);
    t_halt();
    t_wait(1'b1);
    t_wait(1'b0);
    t_bus_reset();
    t_time();
    end_sim();
  end
  initial begin
    repeat (3000) @(posedge clk);
    num_errors++;
    end_sim();
  end
endmodule
`default_nettype wire

//--- mse_cc_if.sv
/*
  Carrier between the execution block and its status-byte update unit.
  Assumes both ends run from the same clock; the update path is combinational.
*/
`timescale 1ns/100ps
`default_nettype none
interface mse_cc_if;
  mse_pkg::mse_ccop_t op;
  logic [7:0] src_byte;
  logic [4:0] sel;
  logic [7:0] ps_cur;
  logic [7:0] ps_nxt;
  modport exec (output op, output src_byte, output sel, output ps_cur, input ps_nxt);
  modport unit (input op, input src_byte, input sel, input ps_cur, output ps_nxt);
endinterface
`default_nettype wire

//--- mse_cc_unit.sv
/*
  Next-value logic for the low status byte under the status moves and
  the condition-code operators.
  Assumes the caller registers the result and selects the operation.
*/
`timescale 1ns/100ps
`default_nettype none
module mse_cc_unit (
  mse_cc_if.unit cc
);
  // ---------------------------------------------------------------
  // Status byte update
  // ---------------------------------------------------------------
  always_comb begin
    cc.ps_nxt = cc.ps_cur;
    unique case (cc.op)
      mse_pkg::CC_NONE: begin
        cc.ps_nxt = cc.ps_cur;
      end
      mse_pkg::CC_MOVE_FROM_STATUS: begin
        // Sign, zero of the whole byte, overflow cleared, carry kept
        cc.ps_nxt[mse_pkg::PS_N_BIT] = cc.ps_cur[mse_pkg::PS_SIGN_BIT];
        cc.ps_nxt[mse_pkg::PS_Z_BIT] = (cc.ps_cur == 8'h00);
        cc.ps_nxt[mse_pkg::PS_V_BIT] = 1'b0;
      end
      mse_pkg::CC_MOVE_TO_STATUS: begin
        // Byte replaced except the trace bit, flags straight from source bits 0-3
        cc.ps_nxt = cc.src_byte;
        // Trace bit may be cleared but never set here
        cc.ps_nxt[mse_pkg::PS_T_BIT] = cc.ps_cur[mse_pkg::PS_T_BIT]
                                       & cc.src_byte[mse_pkg::PS_T_BIT];
      end
      mse_pkg::CC_OPER: begin
        // Bit 4 picks set or clear of the flags chosen by bits 0-3
        if (cc.sel[mse_pkg::CC_SET_BIT]) begin
          cc.ps_nxt[3:0] = cc.ps_cur[3:0] | cc.sel[3:0];
        end else begin
          cc.ps_nxt[3:0] = cc.ps_cur[3:0] & ~cc.sel[3:0];
        end
      end
    endcase
  end
endmodule
`default_nettype wire

//--- mse_exec.sv
/*
  Execution of the miscellaneous and condition-code instructions of a
  16-bit processor: status byte moves, halt, wait, bus reset, flag
  operators, and the instruction time estimate.
  Assumes the fetch and address logic hand over one decoded instruction
  per instr_valid pulse with its effective source byte, destination
  mode and the already advanced program counter.
*/
// Strobed register access and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module mse_exec #(
  parameter int unsigned INIT_CYCLES = mse_pkg::INIT_CYCLES
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic instr_valid,
  input wire logic [15:0] instr,
  input wire logic [15:0] instr_pc,
  input wire logic [7:0] src_byte,
  input wire logic [2:0] dst_mode,
  input wire logic single_op,
  input wire logic is_byte,
  input wire logic [15:0] dst_time_ns,
  input wire logic [15:0] ef_time_ns,
  input wire logic [3:0] mem_cycles,
  input wire logic console_continue_key,
  input wire logic irq_pending,
  output logic [7:0] proc_status,
  output logic dst_wr,
  output logic [15:0] dst_data,
  output logic dst_byte,
  output logic halted,
  output logic [15:0] console_display,
  output logic bus_abort,
  output logic fetch_en,
  output logic irq_grant,
  output logic bus_init,
  output logic [15:0] instr_time_ns,
  output logic time_valid
);
  mse_pkg::mse_state_t state_r;
  logic [7:0] ps_r;
  logic [15:0] rdata_r, dst_data_r, display_r, time_r, time_nxt;
  logic mm_en_r, dst_wr_r, dst_byte_r, abort_r, fetch_en_r, grant_r, time_valid_r, halted_r;
  logic init_start, init_busy, take;
  logic is_move_from_status, is_move_to_status, is_ccop, is_halt, is_wait, is_reset;
  logic [19:0] mm_extra;

  mse_cc_if cc_bus ();

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  // Accepted only while running; no privilege check on status moves
  assign take = instr_valid && (state_r == mse_pkg::ST_RUN);
  assign is_move_from_status = (instr[15:6] == mse_pkg::OP_MOVE_FROM_STATUS_HI);
  assign is_move_to_status = (instr[15:6] == mse_pkg::OP_MOVE_TO_STATUS_HI);
  assign is_ccop = (instr[15:5] == mse_pkg::OP_CCOP_HI);
  assign is_halt = (instr == mse_pkg::OP_HALT);
  assign is_wait = (instr == mse_pkg::OP_WAIT);
  assign is_reset = (instr == mse_pkg::OP_RESET);
  assign init_start = take && is_reset;

  // Flag unit selection; halt, wait and reset leave flags alone
  always_comb begin
    cc_bus.op = mse_pkg::CC_NONE;
    if (take && is_move_from_status) begin
      cc_bus.op = mse_pkg::CC_MOVE_FROM_STATUS;
    end else if (take && is_move_to_status) begin
      cc_bus.op = mse_pkg::CC_MOVE_TO_STATUS;
    end else if (take && is_ccop) begin
      cc_bus.op = mse_pkg::CC_OPER;
    end
  end
  assign cc_bus.src_byte = src_byte;
  assign cc_bus.sel = instr[4:0];
  assign cc_bus.ps_cur = ps_r;

  mse_cc_unit u_cc (
    .cc(cc_bus.unit)
  );

  mse_init_timer #(
    .CYCLES(INIT_CYCLES)
  ) u_init (
    .clk(clk),
    .sys_rst(sys_rst),
    .start(init_start),
    .busy_r(init_busy)
  );

  // ---------------------------------------------------------------
  // Processor status byte
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ps_r <= mse_pkg::PS_RESET;
    end else begin
      ps_r <= cc_bus.ps_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Control state: run, halt, wait, bus init
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r <= mse_pkg::ST_RUN;
      halted_r <= 1'b0;
    end else begin
      unique case (state_r)
        mse_pkg::ST_RUN: begin
          if (take && is_halt) begin
            state_r <= mse_pkg::ST_HALT;
            halted_r <= 1'b1;
          end else if (take && is_wait) begin
            state_r <= mse_pkg::ST_WAIT;
          end else if (take && is_reset) begin
            state_r <= mse_pkg::ST_INIT;
          end
        end
        mse_pkg::ST_HALT: begin
          if (console_continue_key) begin
            state_r <= mse_pkg::ST_RUN;
            halted_r <= 1'b0;
          end
        end
        mse_pkg::ST_WAIT: begin
          if (irq_pending) begin
            state_r <= mse_pkg::ST_RUN;
          end
        end
        mse_pkg::ST_INIT: begin
          // Timer busy rises at the same edge as entry
          if (!init_busy && !init_start) begin
            state_r <= mse_pkg::ST_RUN;
          end
        end
      endcase
    end
  end

  // Fetch permission: none while halted, waiting or resetting the bus
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fetch_en_r <= 1'b1;
    end else if (take && (is_halt || is_wait || is_reset)) begin
      fetch_en_r <= 1'b0;
    end else if (state_r == mse_pkg::ST_HALT && console_continue_key) begin
      fetch_en_r <= 1'b1;
    end else if (state_r == mse_pkg::ST_WAIT && irq_pending) begin
      fetch_en_r <= 1'b1;
    end else if (state_r == mse_pkg::ST_INIT && !init_busy && !init_start) begin
      fetch_en_r <= 1'b1;
    end
  end

  // Halt side effects: abort pulse and console display
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      abort_r <= 1'b0;
      display_r <= 16'h0000;
    end else begin
      abort_r <= take && is_halt;
      if (take && is_halt) begin
        // Program counter already points past the halt
        display_r <= instr_pc;
      end
    end
  end

  // Interrupt grant while waiting, registered one cycle after irq_pending
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      grant_r <= 1'b0;
    end else begin
      grant_r <= (state_r == mse_pkg::ST_WAIT) && irq_pending;
    end
  end

  // ---------------------------------------------------------------
  // Move-from-status destination write
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dst_wr_r <= 1'b0;
      dst_data_r <= 16'h0000;
      dst_byte_r <= 1'b0;
    end else begin
      dst_wr_r <= take && is_move_from_status;
      if (take && is_move_from_status) begin
        dst_byte_r <= 1'b1;
        if (dst_mode == 3'h0) begin
          dst_data_r <= {{8{ps_r[mse_pkg::PS_SIGN_BIT]}}, ps_r};
        end else begin
          dst_data_r <= {8'h00, ps_r};
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Instruction time estimate
  // ---------------------------------------------------------------
  // Byte width and odd address play no part
  assign mm_extra = 20'(mem_cycles) * 20'(mse_pkg::MM_EXTRA_NS);
  always_comb begin
    time_nxt = ef_time_ns;
    if (single_op) begin
      time_nxt = 16'(time_nxt + dst_time_ns);
    end
    if (mm_en_r) begin
      time_nxt = 16'(time_nxt + mm_extra[15:0]);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      time_r <= 16'h0000;
      time_valid_r <= 1'b0;
    end else begin
      time_valid_r <= take;
      if (take) begin
        time_r <= time_nxt;
      end
    end
  end

  // ---------------------------------------------------------------
  // Register port
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mm_en_r <= mse_pkg::CTRL_MM_RESET;
    end else if (reg_wr && reg_addr == mse_pkg::REG_CTRL) begin
      mm_en_r <= reg_wdata[mse_pkg::CTRL_MM_BIT];
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_r <= 16'h0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        mse_pkg::REG_CTRL: rdata_r <= {15'h0000, mm_en_r};
        mse_pkg::REG_STATUS: rdata_r <= {11'h000, init_busy, fetch_en_r, 1'b0, state_r};
        mse_pkg::REG_PS: rdata_r <= {8'h00, ps_r};
        mse_pkg::REG_TIME: rdata_r <= time_r;
        default: rdata_r <= 16'h0000;
      endcase
    end else begin
      rdata_r <= 16'h0000;
    end
  end

  assign reg_rdata = rdata_r;
  assign proc_status = ps_r;
  assign dst_wr = dst_wr_r;
  assign dst_data = dst_data_r;
  assign dst_byte = dst_byte_r;
  assign halted = halted_r;
  assign console_display = display_r;
  assign bus_abort = abort_r;
  assign fetch_en = fetch_en_r;
  assign irq_grant = grant_r;
  assign bus_init = init_busy;
  assign instr_time_ns = time_r;
  assign time_valid = time_valid_r;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  sequence s_take_halt;
    take && is_halt;
  endsequence
  sequence s_halted_shown(logic [15:0] pc);
    halted && console_display == pc && bus_abort && !bus_init;
  endsequence
  sequence s_wait_entry;
    take && is_wait;
  endsequence

  property p_move_from_status_reg;
    @(posedge clk) disable iff (sys_rst)
      take && is_move_from_status && dst_mode == 3'h0 |=>
        dst_wr && dst_data == {{8{$past(ps_r[7])}}, $past(ps_r)};
  endproperty
  a_move_from_status_reg: assert property (p_move_from_status_reg) else $error("status move out wrong");
  property p_move_from_status_flags;
    @(posedge clk) disable iff (sys_rst)
      take && is_move_from_status |=> ps_r[3] == $past(ps_r[7]) && ps_r[2] == ($past(ps_r) == 8'h00)
        && !ps_r[1] && ps_r[0] == $past(ps_r[0]);
  endproperty
  a_move_from_status_flags: assert property (p_move_from_status_flags) else $error("status move flags wrong");
  property p_move_to_status_trace;
    @(posedge clk) disable iff (sys_rst)
      take && is_move_to_status && !ps_r[4] |=> !ps_r[4] && ps_r[3:0] == $past(src_byte[3:0]);
  endproperty
  a_move_to_status_trace: assert property (p_move_to_status_trace) else $error("status load wrong");
  property p_halt;
    logic [15:0] pc;
    @(posedge clk) disable iff (sys_rst)
      (s_take_halt, pc = instr_pc) |=> s_halted_shown(pc) ##1 (!bus_abort && !fetch_en);
  endproperty
  a_halt: assert property (p_halt) else $error("halt sequence wrong");
  property p_continue;
    @(posedge clk) disable iff (sys_rst)
      halted && console_continue_key |=> !halted && fetch_en;
  endproperty
  a_continue: assert property (p_continue) else $error("continue ignored");
  property p_wait;
    @(posedge clk) disable iff (sys_rst)
      s_wait_entry |=> !fetch_en && !dst_wr;
  endproperty
  a_wait: assert property (p_wait) else $error("fetch during wait");
  property p_wait_exit;
    @(posedge clk) disable iff (sys_rst)
      state_r == mse_pkg::ST_WAIT && irq_pending |=> irq_grant && fetch_en;
  endproperty
  a_wait_exit: assert property (p_wait_exit) else $error("interrupt not granted");
  property p_reset_op;
    @(posedge clk) disable iff (sys_rst)
      take && is_reset |=> ps_r == $past(ps_r) ##1 bus_init;
  endproperty
  a_reset_op: assert property (p_reset_op) else $error("bus init missing");

  property p_ccop;
    @(posedge clk) disable iff (sys_rst)
      take && is_ccop |=> ps_r[3:0] == ($past(instr[4]) ? ($past(ps_r[3:0]) | $past(instr[3:0]))
        : ($past(ps_r[3:0]) & ~$past(instr[3:0])));
  endproperty
  a_ccop: assert property (p_ccop) else $error("flag operator wrong");

  property p_time;
    @(posedge clk) disable iff (sys_rst)
      take && !single_op && !mm_en_r |=> time_valid && instr_time_ns == $past(ef_time_ns);
  endproperty
  a_time: assert property (p_time) else $error("time estimate wrong");
endmodule
`default_nettype wire

//--- mse_far_model.sv
/*
  Far-side model: operator console and an interrupting device.
  Assumes the execution block's clock and its synchronous reset.
*/
`timescale 1ns/100ps
`default_nettype none
module mse_far_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic slow,
  input wire logic halted,
  input wire logic fetch_en,
  input wire logic bus_init,
  input wire logic irq_grant,
  output logic console_continue_key,
  output logic irq_pending
);
  logic [5:0] idle_cnt_r;
  logic [5:0] limit;
  assign limit = slow ? 6'h14 : 6'h02;
  // Count cycles with the processor off the bus
  always_ff @(posedge clk) begin
    if (sys_rst || fetch_en || bus_init) idle_cnt_r <= 6'h00;
    else if (idle_cnt_r != 6'h3f) idle_cnt_r <= idle_cnt_r + 6'h01;
  end
  // Operator presses continue once during a halt
  always_ff @(posedge clk) begin
    console_continue_key <= !sys_rst && halted && (idle_cnt_r == limit);
  end
  // Device requests an interrupt in wait, held until granted
  always_ff @(posedge clk) begin
    if (sys_rst || irq_grant) irq_pending <= 1'b0;
    else if (!halted && idle_cnt_r == limit) irq_pending <= 1'b1;
  end
endmodule
`default_nettype wire

//--- mse_init_timer.sv
/*
  Bus initialization pulse generator: a start pulse raises the init level
  for a fixed number of clock cycles.
  Assumes a synchronous active-high reset; a start while busy is ignored.
*/
`timescale 1ns/100ps
`default_nettype none
module mse_init_timer #(
  parameter int unsigned CYCLES = mse_pkg::INIT_CYCLES
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic start,
  output logic busy_r
);
  localparam int unsigned CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
  logic [CW-1:0] count_r;

  // ---------------------------------------------------------------
  // Pulse length counter
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      busy_r <= 1'b0;
      count_r <= '0;
    end else if (!busy_r && start) begin
      busy_r <= 1'b1;
      count_r <= '0;
    end else if (busy_r) begin
      // Level held for exactly CYCLES clocks
      if (count_r == LAST) begin
        busy_r <= 1'b0;
      end
      count_r <= count_r + CW'(1);
    end
  end
endmodule
`default_nettype wire

//--- mse_pkg.sv
/*
  Constants, encodings and types shared by the miscellaneous and
  condition-code execution block and its helper modules.
  Assumes a single 10 MHz clock domain.
*/
`default_nettype none
package mse_pkg;
  // Clock and bus initialization pulse length
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned INIT_TIME_MS = 100;
  localparam int unsigned INIT_CYCLES = INIT_TIME_MS * 1000000 / CLK_PERIOD_NS;
  // Extra time per memory cycle with memory management on, in ns (0.12 us)
  localparam logic [15:0] MM_EXTRA_NS = 16'h0078;

  // Opcodes (full words, or the fixed high part of the word)
  localparam logic [15:0] OP_HALT = 16'h0000;
  localparam logic [15:0] OP_WAIT = 16'h0001;
  localparam logic [15:0] OP_RESET = 16'h0005;
  localparam logic [9:0] OP_MOVE_FROM_STATUS_HI = 10'h237;
  localparam logic [9:0] OP_MOVE_TO_STATUS_HI = 10'h234;
  localparam logic [10:0] OP_CCOP_HI = 11'h005;

  // Status byte fields
  localparam int unsigned PS_C_BIT = 0;
  localparam int unsigned PS_V_BIT = 1;
  localparam int unsigned PS_Z_BIT = 2;
  localparam int unsigned PS_N_BIT = 3;
  localparam int unsigned PS_T_BIT = 4;
  localparam int unsigned PS_SIGN_BIT = 7;
  localparam int unsigned CC_SET_BIT = 4;
  localparam logic [7:0] PS_RESET = 8'h00;

  // Register offsets, fields and reset values
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_PS = 4'h2;
  localparam logic [3:0] REG_TIME = 4'h3;
  localparam int unsigned CTRL_MM_BIT = 0;
  localparam logic CTRL_MM_RESET = 1'b0;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_HALT = 2'b01,
    ST_WAIT = 2'b10,
    ST_INIT = 2'b11
  } mse_state_t;

  typedef enum logic [1:0] {
    CC_NONE = 2'b00,
    CC_MOVE_FROM_STATUS = 2'b01,
    CC_MOVE_TO_STATUS = 2'b10,
    CC_OPER = 2'b11
  } mse_ccop_t;
endpackage
`default_nettype wire
